/* File: eeb_pkg.sv */
// shared constants for the eeprom two-wire byte-write front end
package eeb_pkg;
  localparam int          PAGE_COUNT        = 128;
  localparam int          PAGE_BYTES        = 32;
  localparam int          ARRAY_BYTES       = PAGE_COUNT * PAGE_BYTES;
  localparam int          ADDR_W            = 12;
  localparam logic [3:0]  TYPE_ARRAY        = 4'h a;
  localparam logic [3:0]  TYPE_SERIAL       = 4'h b;
  localparam logic [1:0]  SERIAL_WA1_KEY    = 2'h 2;
  localparam int          SERIAL_BYTES      = 16;
  localparam logic [3:0]  BIT_LAST          = 4'h 7;
  localparam logic [3:0]  BIT_ACK           = 4'h 8;
  localparam int          CLK_HZ            = 40_000_000;
  localparam int          PROG_TIME_US      = 5000;
  localparam int          PROG_CYCLES       = (PROG_TIME_US * (CLK_HZ / 1_000_000));
  localparam int          RECOVER_CLOCKS    = 9;
  typedef enum logic [2:0] {
    EEB_IDLE,
    EEB_DEVADDR,
    EEB_WORD_HI,
    EEB_WORD_LO,
    EEB_DATA,
    EEB_HOLD,
    EEB_PROG
  } eeb_state_t;
endpackage : eeb_pkg

/* File: eeb_mem.sv */
// byte array storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module eeb_mem
  import eeb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output var  logic [7:0]        rd_data
);
  logic [7:0] mem_r [0:ARRAY_BYTES-1];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule : eeb_mem
`default_nettype wire

/* File: eeb_dev.sv */
// two-wire client front end: addressing, word address, byte write and programming cycle
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - sample on clock rise, msb first
// - eight bits then acknowledge slot
// - start is data fall, clock high
// - stop is data rise, clock high
// - standby after power-up
// - stop ends transaction into standby
// - standby after programming cycle ends
// - release data within nine clocks
// - 128 pages of 32 bytes
// - type nibble 1010 selects array
// - type nibble 1011 selects serial region
// - bits 3..1 match select pins
// - bit 0 picks read or write
// - acknowledge only matching address byte
// - first byte gives location bits 11..8
// - serial region needs bits 3..2 = 10
// - second byte gives location bits 7..0
// - acknowledge data byte, host stops (a serial-region data byte is not acknowledged here)
// - stop launches timed programming cycle
// - ignore bus while programming
module eeb_dev
  import eeb_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic [2:0] client_select_pins,
  output var  logic       standby,
  output var  logic       programming,
  output var  logic       serial_sel,
  output var  logic       read_req,
  output var  logic [ADDR_W-1:0] loc_addr,
  output var  logic [7:0] mem_rd_data
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync_r <= 2'h 3;
      sda_sync_r <= 2'h 3;
      pin_s1_r   <= 3'h 0;
      pin_s2_r   <= 3'h 0;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      pin_s1_r   <= client_select_pins;
      pin_s2_r   <= pin_s1_r;
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // byte engine
  eeb_state_t        state_r;
  eeb_state_t        state_nxt;
  logic [3:0]        bit_r;
  logic [7:0]        shift_r;
  logic              ack_slot_r;
  logic              ack_ok_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        data_r;
  logic              serial_r;
  logic              rd_r;
  logic              got_data_r;
  logic [22:0]       prog_cnt_r;
  logic              mem_we;

  wire [7:0] byte_in  = {shift_r[6:0], sda_s};
  wire type_array  = byte_in[7:4] == TYPE_ARRAY;
  wire type_serial = byte_in[7:4] == TYPE_SERIAL;
  wire pins_match  = byte_in[3:1] == pin_s2_r;
  wire dev_match   = (type_array || type_serial) && pins_match;
  // serial region key in first word byte
  wire wa1_ok      = !serial_r || (byte_in[3:2] == SERIAL_WA1_KEY);
  wire byte_done   = scl_rise && (bit_r == BIT_LAST) && !ack_slot_r;
  wire in_byte     = (state_r != EEB_IDLE) && (state_r != EEB_HOLD) && (state_r != EEB_PROG);
  wire prog_done   = (state_r == EEB_PROG) && (prog_cnt_r == 23'(PROG_CNT - 1));
  wire byte_ok     = (state_r == EEB_DEVADDR) ? (dev_match && !byte_in[0])
                   : (state_r == EEB_WORD_HI) ? wa1_ok
                   : (state_r == EEB_DATA)    ? (!serial_r && !got_data_r)
                   : 1'b1;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      EEB_PROG:    state_nxt = prog_done ? EEB_IDLE : EEB_PROG;
      EEB_IDLE:    state_nxt = start_ev ? EEB_DEVADDR : EEB_IDLE;
      // mismatch waits for start; a stop only drops back to standby
      EEB_HOLD:    state_nxt = start_ev ? EEB_DEVADDR : stop_ev ? EEB_IDLE : EEB_HOLD;
      default:
      begin
        if (start_ev)
          state_nxt = EEB_DEVADDR;
        else if (stop_ev)
          state_nxt = (state_r == EEB_DATA && got_data_r) ? EEB_PROG : EEB_IDLE;
        else if (byte_done && !byte_ok)
          state_nxt = EEB_HOLD;
        else if (byte_done)
        begin
          case (state_r)
            EEB_DEVADDR: state_nxt = EEB_WORD_HI;
            EEB_WORD_HI: state_nxt = EEB_WORD_LO;
            EEB_WORD_LO: state_nxt = EEB_DATA;
            EEB_DATA:    state_nxt = EEB_DATA;
            default:     state_nxt = EEB_HOLD;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r    <= EEB_IDLE;
      bit_r      <= 4'h 0;
      shift_r    <= 8'h 00;
      ack_slot_r <= 1'b0;
      ack_ok_r   <= 1'b0;
      addr_r     <= 12'h 000;
      data_r     <= 8'h 00;
      serial_r   <= 1'b0;
      rd_r       <= 1'b0;
      got_data_r <= 1'b0;
      prog_cnt_r <= 23'h 0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == EEB_PROG)
        prog_cnt_r <= prog_cnt_r + 23'h 1;
      else
        prog_cnt_r <= 23'h 0;
      if (start_ev || !in_byte)
      begin
        bit_r      <= 4'h 0;
        ack_slot_r <= 1'b0;
        ack_ok_r   <= 1'b0;
        if (start_ev)
          got_data_r <= 1'b0;
      end
      else if (scl_rise && ack_slot_r)
      begin
        bit_r      <= 4'h 0;
        ack_slot_r <= 1'b0;
      end
      else if (byte_done)
      begin
        bit_r      <= BIT_ACK;
        ack_slot_r <= 1'b1;
        ack_ok_r   <= byte_ok;
        case (state_r)
          EEB_DEVADDR:
          begin
            serial_r <= type_serial;
            rd_r     <= byte_in[0];
          end
          EEB_WORD_HI: addr_r[11:8] <= byte_in[3:0];
          // lower location bits, serial keeps 4..0
          EEB_WORD_LO: addr_r[7:0]  <= serial_r ? {3'h 0, byte_in[4:0]} : byte_in;
          EEB_DATA:
          begin
            data_r     <= byte_in;
            got_data_r <= 1'b1;
          end
          default: data_r <= data_r;
        endcase
      end
      else if (scl_rise)
      begin
        shift_r <= byte_in;
        bit_r   <= bit_r + 4'h 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data line drive: pull low only during an accepted ack slot
  // line released outside ack slot
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      if (start_ev || stop_ev || !in_byte)
        sda_oe <= 1'b0;
      else if (scl_fall)
        sda_oe <= ack_slot_r && ack_ok_r;
    end
  end

  assign mem_we = prog_done;

  // 4096-byte array behind the front end
  eeb_mem u_mem (
    .clock   (clock),
    .wr_en   (mem_we),
    .wr_addr (addr_r),
    .wr_data (data_r),
    .rd_addr (addr_r),
    .rd_data (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // status outputs
  // standby whenever idle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      standby     <= 1'b1;
      programming <= 1'b0;
      serial_sel  <= 1'b0;
      read_req    <= 1'b0;
      loc_addr    <= 12'h 000;
    end
    else
    begin
      standby     <= state_nxt == EEB_IDLE;
      programming <= state_nxt == EEB_PROG;
      serial_sel  <= serial_r;
      read_req    <= rd_r;
      loc_addr    <= addr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  prog_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == EEB_PROG) |-> !sda_oe)
    else $error("data line driven while programming");
  prog_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    (stop_ev && state_r == EEB_DATA && got_data_r) |=> (state_r == EEB_PROG))
    else $error("stop after data did not start programming");
  prog_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    prog_done |=> ((state_r == EEB_IDLE) && standby))
    else $error("no standby after programming");
  stop_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
    (stop_ev && in_byte && !(state_r == EEB_DATA && got_data_r)) |=> (state_r == EEB_IDLE))
    else $error("stop did not return to standby");
  start_det_a: assert property (@(posedge clock) disable iff (!rst_b)
    (start_ev && state_r != EEB_PROG) |=> (state_r == EEB_DEVADDR))
    else $error("start not detected");
  nomatch_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (byte_done && state_r == EEB_DEVADDR && !dev_match && !start_ev && !stop_ev) |=> (state_r == EEB_HOLD))
    else $error("mismatch did not hold off");
  hold_release_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == EEB_HOLD) |=> !sda_oe)
    else $error("line driven after refusal");
  data_once_a: assert property (@(posedge clock) disable iff (!rst_b)
    (byte_done && state_r == EEB_DATA && got_data_r && !start_ev && !stop_ev) |=> (state_r == EEB_HOLD))
    else $error("second data byte accepted");
  hi_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
    (byte_done && state_r == EEB_WORD_HI && !start_ev && !stop_ev) |=> (addr_r[11:8] == $past(byte_in[3:0])))
    else $error("upper location bits wrong");
  lo_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
    (byte_done && state_r == EEB_WORD_LO && !serial_r && !start_ev && !stop_ev) |=> (addr_r[7:0] == $past(byte_in)))
    else $error("lower location bits wrong");
endmodule : eeb_dev
`default_nettype wire

/* File: eeb_host.sv */
// two-wire bus host model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module eeb_host
(
  input  wire logic clock,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  //////////////////////////////////////////////////////////////////////////////
  // change while low, sample high
  task automatic clk_bit(input logic b, output logic got);
    sda_low = !b;
    tick(3);
    scl = 1'b1;
    tick(2);
    got = sda_line;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask : clk_bit
  task automatic start();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b0;
    tick(3);
  endtask : stop
  // msb first, line released in the ninth clock
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
      clk_bit(v[i], g);
    clk_bit(1'b1, g);
    ack = !g;
  endtask : send_byte
endmodule : eeb_host
`default_nettype wire

/* File: test_eeprom_i2c_address_and_byte_write.sv */
// self-checking bench for the two-wire byte-write front end
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_i2c_address_and_byte_write;
  import eeb_pkg::*;
  // short programming time keeps the run brief; must outlast one busy attempt
  localparam int PCNT = 400;
  logic              clock, rst_b, scl, sda_low, sda_out, sda_oe;
  logic              standby, programming, serial_sel, read_req;
  logic [2:0]        pins;
  logic [ADDR_W-1:0] loc_addr;
  logic [7:0]        mem_rd_data;
  wire logic         sda_line = !(sda_low || (sda_oe && !sda_out));
  int                failures, compares;
  int                seed = 32'h659d_25c9;
  int                exp_mem [int];
  logic [31:0]       cases [6] = '{32'haa03_7c5a, 32'hac01_0011, 32'hab01_0011,
                                   32'hba08_1f33, 32'hba04_0133, 32'haa0f_ff00};
  eeb_dev #(.PROG_CNT(PCNT)) DUT (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .client_select_pins(pins), .standby(standby),
    .programming(programming), .serial_sel(serial_sel), .read_req(read_req),
    .loc_addr(loc_addr), .mem_rd_data(mem_rd_data));
  eeb_host host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_done;
    int n = 0;
    while (programming === 1'b1 && n < PCNT + 10)
    begin
      @(negedge clock);
      n++;
    end
    if (programming !== 1'b0)
    begin
      failures++;
      end_of_test;
    end
    @(negedge clock);
  endtask : wait_done
  task automatic run_case(input logic [31:0] c);
    logic [7:0] a, w1, w2, d;
    logic [3:0] ack, e;
    logic       arr, b;
    int         addr;
    {a, w1, w2, d} = c;
    arr = a[7:4] == TYPE_ARRAY;
    e[3] = (arr || a[7:4] == TYPE_SERIAL) && a[3:1] == pins && !a[0];
    e[2] = e[3] && (arr || w1[3:2] == SERIAL_WA1_KEY);
    e[1] = e[2];
    e[0] = e[1] && arr;
    addr = arr ? {w1[3:0], w2} : {w1[3:0], 3'h0, w2[4:0]};
    host.start();
    for (int i = 3; i >= 0; i--)
      host.send_byte(c[i*8 +: 8], ack[i]);
    host.stop();
    repeat (6) @(negedge clock);
    chk("ack", e, ack);
    chk("read_req", a[0], read_req);
    if (e[1])
      chk("loc_addr", addr, loc_addr);
    if (e[1])
      chk("serial_sel", !arr, serial_sel);
    chk("programming", e[0], programming);
    chk("standby", !e[0], standby);
    if (e[0])
    begin
      exp_mem[addr] = d;
      host.start();
      host.send_byte(a, b);
      host.stop();
      chk("busy ack", 0, b);
      wait_done;
      chk("standby", 1, standby);
      chk("mem_rd_data", exp_mem[addr], mem_rd_data);
    end
  endtask : run_case
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    logic        g;
    int          n;
    rst_b = 1'b0;
    pins = 3'h5;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    chk("standby", 1, standby);
    chk("sda_oe", 0, sda_oe);
    repeat (4) @(negedge clock);
    foreach (cases[i])
      run_case(cases[i]);
    // device holds the line in the ack slot; dummy clocks must free it
    host.start();
    for (int i = 7; i >= 0; i--)
      host.clk_bit(cases[0][24 + i], g);
    n = 0;
    g = 1'b0;
    while (!g && n < 10)
    begin
      host.clk_bit(1'b1, g);
      n++;
    end
    chk("released", 1, g && n <= RECOVER_CLOCKS);
    host.stop();
    // a second data byte is refused, so nothing gets programmed
    host.start();
    for (int i = 3; i >= 0; i--)
      host.send_byte(cases[0][i*8 +: 8], g);
    host.send_byte(8'h3c, g);
    host.stop();
    repeat (6) @(negedge clock);
    chk("extra data ack", 0, g);
    chk("programming", 0, programming);
    repeat (8)
    begin
      r = $random(seed);
      pins = r[9:7];
      run_case({3'b101, r[0], r[1] ? r[9:7] : r[4:2], r[5] & r[6], 8'(r[17:10] & 8'h0b),
                8'($random(seed)), 8'($random(seed))});
    end
    end_of_test;
  end
endmodule : test_eeprom_i2c_address_and_byte_write
`default_nettype wire
